// ---- backlight_pkg.sv ----
/*
  Shared constants for the backlight control register bank: register
  offsets, field positions, reset values and timing figures.
  Assumes a 100 MHz register clock and byte-wide registers.
*/
package backlight_pkg;

   // Register offsets on the byte register port
   localparam logic [7:0] OFF_PWM_LEVEL  = 8'h00;
   localparam logic [7:0] OFF_DEV_CTRL   = 8'h01;
   localparam logic [7:0] OFF_STATUS     = 8'h02;
   localparam logic [7:0] OFF_IDENT      = 8'h03;
   localparam logic [7:0] OFF_DC_LEVEL   = 8'h07;
   localparam logic [7:0] OFF_CONFIG     = 8'h08;
   localparam logic [7:0] OFF_CHANNELS   = 8'h09;

   // Reset values
   localparam logic [7:0] RST_PWM_LEVEL  = 8'hff;
   localparam logic [7:0] RST_DEV_CTRL   = 8'h00;
   localparam logic [7:0] RST_DC_LEVEL   = 8'hff;
   localparam logic [7:0] RST_CONFIG     = 8'h1f;
   localparam logic [7:0] RST_CHANNELS   = 8'h3f;
   localparam logic [7:0] READ_UNMAPPED  = 8'h00;

   // Device control fields
   localparam int CTL_ON_REQ  = 0;
   localparam int CTL_SRC_SEL = 1;
   localparam int CTL_BLEND   = 2;

   // Status fields
   localparam int ST_FAULT    = 0;
   localparam int ST_OVERTEMP = 1;
   localparam int ST_OVERCURR = 2;
   localparam int ST_ON_FLAG  = 3;
   localparam int ST_ONE_DOWN = 4;
   localparam int ST_TWO_DOWN = 5;

   // Configuration fields
   localparam int CFG_SHORT   = 0;
   localparam int CFG_RATE    = 2;
   localparam int CFG_DRIVE_L = 3;
   localparam int CFG_DRIVE_H = 4;

   // Identification layout
   localparam logic       ID_KIND_BIT   = 1'b1;
   localparam int         NUM_CHANNELS  = 6;

   // Duty figures
   localparam logic [7:0] DUTY_FULL     = 8'hff;
   localparam logic [7:0] DUTY_NONE     = 8'h00;
   localparam logic [1:0] TWO_DOWN_MIN  = 2'h2;

   // Turn-on bound
   localparam int CLK_PERIOD_NS  = 10;
   localparam int ON_MAX_MS      = 4;
   localparam int ON_MAX_CYCLES  = (ON_MAX_MS * 1000000) / CLK_PERIOD_NS;

endpackage : backlight_pkg

// ---- backlight_regs.sv ----
/*
  Backlight control register bank: byte registers written and read by
  the two-wire protocol engine, backlight on/off sequencing, dimming
  source selection, sticky fault summary and channel readout.
  Assumes reg_wr/reg_rd are one-cycle pulses on ref_clk from the
  protocol engine; fault and PWM pins are asynchronous.
*/
// What this block does
// - Reserved device control bits read zero until written, and steer nothing.
// - Defined device control bits read back their latched values.
// - Backlight is running within four milliseconds after the on request is set.
// - Backlight is on only when the on flag is one and channels read nonzero.
// - Clearing the on request turns off at once; flag and channels read zero.
// - Device control resets to all zeros.
// - Source select one makes brightness follow only the external PWM input.
// - Source zero, blend one: duty comes only from the programmed PWM level.
// - Both mode bits zero: duty equals programmed level times measured PWM duty.
// - Reserved status bits read zero and ignore writes.
// - Status bits are read-only except the summary fault bit, writable to clear.
// - The on flag shows the present on or off state.
// - Summary fault is set by overtemp, overcurrent or channel-down, never on flag.
// - One-down reads one for any faulted channel, two-down for two or more.
// - Summary fault sticks; clears on on-request toggle or zero write.
// - Identification is read-only: top bit one, 4-bit maker, 3-bit revision.
// - DC level scales string current linearly over 256 codes, applied on the fly.
// - DC level resets to all ones and is fully readable and writable.
// - Configuration holds a two-bit switch drive strength field.
// - A configuration bit selects the boost switching rate.
// - A configuration bit enables or disables string short detection.
// - Configuration resets to 0x1f.
// - Drive strength codes 00..11 give 25, 50, 75 and 100 percent.
// - Short guard bit zero disables, one enables short protection.
// - Channel readout shows zero for disabled or faulted-out channels.
// - PWM level codes 1..255 map linearly to duty; code 0 is minimum.
`timescale 1ns/1ps
module backlight_regs #(
   parameter int         ON_DELAY_CYCLES = backlight_pkg::ON_MAX_CYCLES,
   parameter int         METER_W         = 20,
   parameter logic [3:0] MAKER_CODE      = 4'h5,  // Arbitrary value
   parameter logic [2:0] REVISION        = 3'h0
) (
   input  wire logic       ref_clk,               // 100 MHz block clock
   input  wire logic       resetn,                // Async reset, active low
   input  wire logic       reg_wr,                // Write strobe, one cycle
   input  wire logic       reg_rd,                // Read strobe, one cycle
   input  wire logic [7:0] reg_addr,              // Register offset
   input  wire logic [7:0] reg_wdata,             // Write data
   output      logic [7:0] reg_rdata,             // Read data, registered
   output      logic       reg_rvalid,            // Read data valid pulse
   input  wire logic       ext_pwm_in,            // External PWM pin
   input  wire logic       overtemp_in,           // Overtemperature pin
   input  wire logic       overcurrent_in,        // Input overcurrent pin
   input  wire logic [5:0] chan_fault_in,         // Per-channel fault pins
   output      logic       backlight_on,          // Backlight running
   output      logic [7:0] dim_duty,              // PWM dimming duty, 255 = 100%
   output      logic [7:0] dc_level,              // String current scale
   output      logic [5:0] chan_drive,            // Channels driven
   output      logic [1:0] switch_drive_strength, // Boost gate drive code
   output      logic       switching_rate_select, // Boost rate select
   output      logic       short_guard_select     // Short detection enable
);

   typedef enum logic [2:0]
   {
      BL_OFF  = 3'b001,
      BL_RAMP = 3'b010,
      BL_ON   = 3'b100
   } bl_state_e;

   localparam int RAMP_W = $clog2(ON_DELAY_CYCLES + 1);
   localparam int N = backlight_pkg::NUM_CHANNELS;

   bl_state_e   state_r;
   logic [RAMP_W-1:0] ramp_cnt_r;
   logic [7:0]  pwm_level_r;
   logic [7:0]  device_control_r;
   logic [7:0]  dc_level_r;
   logic [7:0]  configuration_r;
   logic [5:0]  channel_enable_bits_r;
   logic [5:0]  chan_down_r;
   logic        fault_r;
   logic        on_req_d_r;
   logic [8:0]  sync_in;
   logic [8:0]  sync_out;
   logic        pwm_sync;
   logic        overtemp_flag;
   logic        overcurrent_flag;
   logic [5:0]  chan_fault_s;
   logic [7:0]  meas_duty;
   logic        backlight_on_request;
   logic        dimming_source_select;
   logic        dimming_blend_select;
   logic        backlight_on_flag;
   logic        one_channel_down;
   logic        two_channels_down;
   logic [2:0]  down_count;
   logic        fault_cause;
   logic        fault_clear;
   logic [15:0] scaled_prod;
   logic [7:0]  duty_nxt;
   logic [5:0]  chan_readout;
   logic [7:0]  status_read;
   logic [7:0]  ident_read;
   logic [7:0]  rdata_nxt;
   logic        wr_ctrl;

   // All pin inputs pass two flops before use
   assign sync_in = {chan_fault_in, overcurrent_in, overtemp_in, ext_pwm_in};

   sync_two_flop #(
      .WIDTH    (9)
   ) u_sync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .async_in (sync_in),
      .sync_out (sync_out)
   );

   assign pwm_sync         = sync_out[0];
   assign overtemp_flag    = sync_out[1];
   assign overcurrent_flag = sync_out[2];
   assign chan_fault_s     = sync_out[8:3];

   pwm_duty_meter #(
      .CNT_W    (METER_W)
   ) u_meter (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .pwm_sync (pwm_sync),
      .duty_r   (meas_duty)
   );

   // Decoded control fields; reserved bits are stored but never decoded
   assign backlight_on_request  = device_control_r[backlight_pkg::CTL_ON_REQ];
   assign dimming_source_select = device_control_r[backlight_pkg::CTL_SRC_SEL];
   assign dimming_blend_select  = device_control_r[backlight_pkg::CTL_BLEND];
   assign wr_ctrl = reg_wr && (reg_addr == backlight_pkg::OFF_DEV_CTRL);

   // Writable registers; all but channels store the whole byte so reserved bits read back
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pwm_level_r      <= backlight_pkg::RST_PWM_LEVEL;
         device_control_r <= backlight_pkg::RST_DEV_CTRL;
         dc_level_r       <= backlight_pkg::RST_DC_LEVEL;
         configuration_r  <= backlight_pkg::RST_CONFIG;
         channel_enable_bits_r <= backlight_pkg::RST_CHANNELS[5:0];
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            backlight_pkg::OFF_PWM_LEVEL: pwm_level_r      <= reg_wdata;
            backlight_pkg::OFF_DEV_CTRL:  device_control_r <= reg_wdata;
            backlight_pkg::OFF_DC_LEVEL:  dc_level_r       <= reg_wdata;
            backlight_pkg::OFF_CONFIG:    configuration_r  <= reg_wdata;
            backlight_pkg::OFF_CHANNELS:  channel_enable_bits_r <= reg_wdata[5:0];
            default:                      ;  // Status writes act only through fault_clear; ident ignores writes
         endcase
      end
   end

   // On sequencing: turn-on waits the ramp count, turn-off is immediate
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r    <= BL_OFF;
         ramp_cnt_r <= '0;
      end
      else
      begin
         unique case (state_r)
            BL_OFF:
            begin
               ramp_cnt_r <= '0;
               if (backlight_on_request)
                  state_r <= BL_RAMP;
            end
            BL_RAMP:
            begin
               ramp_cnt_r <= ramp_cnt_r + RAMP_W'(1);
               if (!backlight_on_request)
                  state_r <= BL_OFF;
               else if (ramp_cnt_r >= RAMP_W'(ON_DELAY_CYCLES - 2))
                  state_r <= BL_ON;
            end
            BL_ON:
            begin
               if (!backlight_on_request)
                  state_r <= BL_OFF;
            end
         endcase
      end
   end

   // Flag is the present state, and channels go dark with it
   assign backlight_on_flag = (state_r == BL_ON);
   assign chan_readout = channel_enable_bits_r & ~chan_down_r
                         & {N{backlight_on_flag}};
   assign backlight_on = backlight_on_flag && (chan_readout != '0);

   // Faulted channels latch out until disabled; re-enable retries them
   generate
      for (genvar i = 0; i < N; i++)
      begin : g_chan
         always_ff @(posedge ref_clk or negedge resetn)
         begin
            if (!resetn)
               chan_down_r[i] <= 1'b0;
            else if (chan_fault_s[i] && channel_enable_bits_r[i] && backlight_on_flag)
               chan_down_r[i] <= 1'b1;
            else if (!channel_enable_bits_r[i])
               chan_down_r[i] <= 1'b0;
         end
      end
   endgenerate

   // Count of faulted-out channels
   always_comb
   begin
      down_count = '0;
      for (int k = 0; k < N; k++)
         down_count = down_count + 3'(chan_down_r[k]);
   end

   assign one_channel_down  = (down_count != '0);
   assign two_channels_down = (down_count >= 3'(backlight_pkg::TWO_DOWN_MIN));

   // Summary fault: any fault cause, never the on flag
   assign fault_cause = overtemp_flag | overcurrent_flag
                        | one_channel_down | two_channels_down;
   assign fault_clear = (on_req_d_r != backlight_on_request)
                        || (reg_wr && (reg_addr == backlight_pkg::OFF_STATUS)
                            && !reg_wdata[backlight_pkg::ST_FAULT]);

   // Set wins over clear so a persisting cause sets it again at once
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fault_r    <= 1'b0;
         on_req_d_r <= 1'b0;
      end
      else
      begin
         on_req_d_r <= backlight_on_request;
         if (fault_cause)
            fault_r <= 1'b1;
         else if (fault_clear)
            fault_r <= 1'b0;
      end
   end

   // Dimming duty selection; off always gives zero
   always_comb
   begin
      scaled_prod = pwm_level_r * meas_duty;
      duty_nxt    = backlight_pkg::DUTY_NONE;
      if (!backlight_on_flag)
         duty_nxt = backlight_pkg::DUTY_NONE;
      else if (dimming_source_select)
         duty_nxt = meas_duty;
      else if (dimming_blend_select)
         duty_nxt = pwm_level_r;
      else if (meas_duty == backlight_pkg::DUTY_FULL)
         duty_nxt = pwm_level_r;
      else
         duty_nxt = scaled_prod[15:8];
   end

   // Data outputs from flops; boost settings follow the register directly
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dim_duty   <= backlight_pkg::DUTY_NONE;
         chan_drive <= '0;
      end
      else
      begin
         dim_duty   <= duty_nxt;
         chan_drive <= chan_readout;
      end
   end

   assign dc_level = dc_level_r;
   assign switch_drive_strength = configuration_r[backlight_pkg::CFG_DRIVE_H:
                                                  backlight_pkg::CFG_DRIVE_L];
   assign switching_rate_select = configuration_r[backlight_pkg::CFG_RATE];
   assign short_guard_select    = configuration_r[backlight_pkg::CFG_SHORT];

   // Status and identification images; reserved status bits stay zero
   always_comb
   begin
      status_read = '0;
      status_read[backlight_pkg::ST_FAULT]    = fault_r;
      status_read[backlight_pkg::ST_OVERTEMP] = overtemp_flag;
      status_read[backlight_pkg::ST_OVERCURR] = overcurrent_flag;
      status_read[backlight_pkg::ST_ON_FLAG]  = backlight_on_flag;
      status_read[backlight_pkg::ST_ONE_DOWN] = one_channel_down;
      status_read[backlight_pkg::ST_TWO_DOWN] = two_channels_down;
   end

   assign ident_read = {backlight_pkg::ID_KIND_BIT, MAKER_CODE, REVISION};

   // Read multiplexer; unmapped offsets read zero
   always_comb
   begin
      unique case (reg_addr)
         backlight_pkg::OFF_PWM_LEVEL: rdata_nxt = pwm_level_r;
         backlight_pkg::OFF_DEV_CTRL:  rdata_nxt = device_control_r;
         backlight_pkg::OFF_STATUS:    rdata_nxt = status_read;
         backlight_pkg::OFF_IDENT:     rdata_nxt = ident_read;
         backlight_pkg::OFF_DC_LEVEL:  rdata_nxt = dc_level_r;
         backlight_pkg::OFF_CONFIG:    rdata_nxt = configuration_r;
         backlight_pkg::OFF_CHANNELS:  rdata_nxt = {2'b00, chan_readout};
         default:                      rdata_nxt = backlight_pkg::READ_UNMAPPED;
      endcase
   end

   // Read data is captured on the strobe and held until the next read
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         reg_rdata  <= backlight_pkg::READ_UNMAPPED;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= rdata_nxt;
      end
   end

   // Checks on the block's own behaviour
   a_ctrl_reset: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(resetn) |-> device_control_r == backlight_pkg::RST_DEV_CTRL)
      else $error("Device control not zero after reset");

   a_on_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
      state_r == BL_RAMP |-> ramp_cnt_r < RAMP_W'(ON_DELAY_CYCLES))
      else $error("Turn-on took longer than the bound");

   a_off_at_once: assert property (@(posedge ref_clk) disable iff (!resetn)
      !backlight_on_request |=> !backlight_on_flag && chan_readout == '0)
      else $error("Backlight not off after request cleared");

   a_ext_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
      backlight_on_flag && dimming_source_select |=> dim_duty == $past(meas_duty))
      else $error("External mode duty differs from measured duty");

   a_blend_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
      backlight_on_flag && !dimming_source_select && dimming_blend_select
      |=> dim_duty == $past(pwm_level_r))
      else $error("Register mode duty differs from level");

   a_scaled_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
      backlight_on_flag && device_control_r[2:1] == 2'b00 && meas_duty != 8'hff
      |=> dim_duty == 8'((16'($past(pwm_level_r)) * 16'($past(meas_duty))) >> 8))
      else $error("Scaled duty wrong");

   a_fault_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
      fault_cause |=> fault_r)
      else $error("Fault cause did not set summary");

   a_fault_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
      fault_r && !fault_clear |=> fault_r)
      else $error("Summary fault dropped without clear");

   a_status_rsv: assert property (@(posedge ref_clk) disable iff (!resetn)
      reg_rd && reg_addr == backlight_pkg::OFF_STATUS |=> reg_rdata[7:6] == 2'b00)
      else $error("Reserved status bits nonzero");

   a_two_down: assert property (@(posedge ref_clk) disable iff (!resetn)
      two_channels_down |-> one_channel_down && $countones(chan_down_r) >= 2)
      else $error("Channel-down flags inconsistent");

   a_ident_fixed: assert property (@(posedge ref_clk) disable iff (!resetn)
      reg_rd && reg_addr == backlight_pkg::OFF_IDENT
      |=> reg_rdata[7] == 1'b1 && $stable(ident_read))
      else $error("Identification changed");

   c_turn_on: cover property (@(posedge ref_clk) disable iff (!resetn)
      state_r == BL_RAMP ##1 state_r == BL_ON);
   c_fault_clear: cover property (@(posedge ref_clk) disable iff (!resetn)
      fault_r ##1 !fault_r);
   c_scaled_on: cover property (@(posedge ref_clk) disable iff (!resetn)
      backlight_on_flag && device_control_r[2:1] == 2'b00 && meas_duty != '0);

endmodule : backlight_regs

// ---- backlight_regs_tb.sv ----
/*
  Self-checking bench for the backlight register bank.
  Assumes the one-cycle strobe register port and a short turn-on delay.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
module backlight_regs_tb;
   logic ref_clk, resetn, reg_wr, reg_rd, ext_pwm_in, overtemp_in, overcurrent_in, run;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, dim_duty, dc_level, v, lvl;
   logic [5:0] chan_fault_in, chan_drive;
   logic [1:0] switch_drive_strength;
   logic       reg_rvalid, backlight_on, switching_rate_select, short_guard_select;
   int         mismatches, n_tests, seed, k, mdl[16];
   int         modes[3] = '{3, 5, 1};
   localparam int ON_CYC = 8;  // Short ramp stands in for the turn-on bound
   backlight_regs #(.ON_DELAY_CYCLES(ON_CYC), .METER_W(10)) u_backlight_regs (
      .ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .ext_pwm_in(ext_pwm_in), .overtemp_in(overtemp_in),
      .overcurrent_in(overcurrent_in), .chan_fault_in(chan_fault_in),
      .backlight_on(backlight_on), .dim_duty(dim_duty), .dc_level(dc_level),
      .chan_drive(chan_drive), .switch_drive_strength(switch_drive_strength),
      .switching_rate_select(switching_rate_select),
      .short_guard_select(short_guard_select));
   pwm_source u_pwm_source (.run(run), .pwm_out(ext_pwm_in));
   // Clock, 10 ns period
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(posedge ref_clk);
      #1 reg_wr = 1'b0;
      if (a != 2 && a != 3)
         mdl[a] = d;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      #1 {reg_rd, reg_addr} = {1'b1, a};
      @(posedge ref_clk);
      #1 reg_rd = 1'b0;
      `CHK("rvalid", 1'b1, reg_rvalid)
      `CHK("rdata", e, reg_rdata)
   endtask : rd
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   // Main sequence; pins are held quiet until each test needs them
   initial
   begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, run} = '0;
      {overtemp_in, overcurrent_in, chan_fault_in} = '0;
      seed = 14191;
      mdl = '{0: 'hff, 3: 'ha8, 7: 'hff, 8: 'h1f, default: 0};
      resetn = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 resetn = 1'b1;
      for (k = 0; k < 10; k++) rd(k, mdl[k]);
      `CHK("drive", 2'b11, switch_drive_strength)
      $display("reset values done");
      wr(1, 8'hf8);
      rd(1, 8'hf8);
      `CHK("on", 1'b0, backlight_on)
      wr(3, 8'h00);
      wr(2, 8'hc0);
      rd(3, 8'ha8);
      rd(2, 8'h00);
      v = $random(seed);
      wr(7, v);
      rd(7, v);
      `CHK("dc", v, dc_level)
      v = $random(seed);
      wr(8, v);
      `CHK("cfg", {v[4:3], v[2], v[0]}, {switch_drive_strength, switching_rate_select, short_guard_select})
      $display("access done");
      run = 1'b1;
      wr(1, 8'h01);
      // Poll 1 ns after each edge so the flag is settled when looked at
      for (k = 0; k < 40 && backlight_on !== 1'b1; k++) #10;
      if (k == 40)
      begin
         mismatches++;
         test_done;
      end
      `CHK("on time", 1'b1, k <= ON_CYC)
      rd(2, 8'h08);
      rd(9, 8'h3f);
      $display("turn on done");
      lvl = $random(seed);
      wr(0, lvl);
      repeat (80) @(posedge ref_clk);
      foreach (modes[i])
      begin
         wr(1, modes[i]);
         #40;
         `CHK("duty", modes[i] == 3 ? 8'd64 : modes[i] == 5 ? lvl : 8'((lvl * 64) >> 8), dim_duty)
      end
      $display("dimming done");
      {overtemp_in, overcurrent_in} = 2'b11;
      repeat (5) @(posedge ref_clk);
      rd(2, 8'h0f);
      {overtemp_in, overcurrent_in} = 2'b00;
      repeat (5) @(posedge ref_clk);
      rd(2, 8'h09);
      wr(2, 8'h00);
      rd(2, 8'h08);
      chan_fault_in = 6'h03;
      repeat (5) @(posedge ref_clk);
      rd(2, 8'h39);
      rd(9, 8'h3c);
      `CHK("on", 1'b1, backlight_on)
      $display("faults done");
      wr(1, 8'h00);
      #10;
      `CHK("off", 1'b0, backlight_on)
      rd(9, 8'h00);
      rd(2, 8'h31);
      `CHK("dark", 1'b0, (|chan_drive) | (|dim_duty))
      $display("turn off done");
      test_done;
   end
endmodule : backlight_regs_tb

// ---- pwm_duty_meter.sv ----
/*
  Measures the duty fraction of a synchronised PWM input as an 8-bit
  value, full scale = 255. Assumes the input is already synchronised.
*/
`timescale 1ns/1ps
module pwm_duty_meter #(
   parameter int CNT_W = 20
) (
   input  wire logic       ref_clk,    // Block clock
   input  wire logic       resetn,     // Async reset, active low
   input  wire logic       pwm_sync,   // Synchronised PWM level
   output      logic [7:0] duty_r      // Last measured duty, 255 = 100%
);

   logic             pwm_d_r;
   logic [CNT_W-1:0] period_cnt_r;
   logic [CNT_W-1:0] high_cnt_r;
   logic [CNT_W+7:0] quot;
   logic             rise;
   logic             stalled;

   assign rise    = pwm_sync & ~pwm_d_r;
   assign stalled = &period_cnt_r;

   // Ratio of high time to period, scaled to 256 and clipped
   always_comb
   begin
      quot = '0;
      if (period_cnt_r != '0)
         quot = {high_cnt_r, 8'h00} / {8'h00, period_cnt_r};
   end

   // Counters restart on each rising edge; saturate on a stuck input
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pwm_d_r      <= 1'b0;
         period_cnt_r <= '0;
         high_cnt_r   <= '0;
      end
      else
      begin
         pwm_d_r <= pwm_sync;
         if (rise)
         begin
            period_cnt_r <= CNT_W'(1);
            high_cnt_r   <= CNT_W'(1);
         end
         else if (!stalled)
         begin
            period_cnt_r <= period_cnt_r + CNT_W'(1);
            high_cnt_r   <= high_cnt_r + CNT_W'(pwm_sync);
         end
      end
   end

   // A stuck input reads as 0% or 100% rather than the stale figure
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         duty_r <= backlight_pkg::DUTY_NONE;
      else if (stalled)
         duty_r <= pwm_sync ? backlight_pkg::DUTY_FULL : backlight_pkg::DUTY_NONE;
      else if (rise)
         duty_r <= (quot > CNT_W'(255)) ? backlight_pkg::DUTY_FULL : quot[7:0];
   end

endmodule : pwm_duty_meter

// ---- pwm_source.sv ----
/*
  External PWM source for the bench: 160 ns period, 40 ns high.
  Assumes the receiver samples the line asynchronously.
*/
`timescale 1ns/1ps
module pwm_source (
   input  wire logic run,    // Frames run while high
   output      logic pwm_out // PWM level
);
   // Line stays low while stopped, offset from the clock edges
   initial
   begin
      pwm_out = 1'b0;
      #3;
      forever
      begin
         pwm_out = run;
         #40 pwm_out = 1'b0;
         #120;
      end
   end
endmodule : pwm_source

// ---- sync_two_flop.sv ----
/*
  Two-flop level synchroniser, one stage pair per bit.
  Assumes inputs are levels that stay stable for several clocks.
*/
`timescale 1ns/1ps
module sync_two_flop #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,   // Block clock
   input  wire logic             resetn,    // Async reset, active low
   input  wire logic [WIDTH-1:0] async_in,  // Levels from outside
   output      logic [WIDTH-1:0] sync_out   // Synchronised levels
);

   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_r   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : sync_two_flop
